// File: include/boot_sel_pkg.sv
// Purpose: Shared constants for boot-time host interface selection.
// Assumes: 40 MHz clock, 16-bit register data on the plain register port.
// Notes: Register offsets are word indices on the plain register port.
package boot_sel_pkg;
    // ----------------------------------------------------------------
    // Clock and timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ = 40000000;
    localparam int unsigned MIN_RATE_BPS = 57600;
    localparam int unsigned MAX_RATE_BPS = 115200;
    // Longest legal bit time in cycles, rounded up.
    localparam logic [15:0] MAX_BIT_CYC = 16'((CLK_HZ + MIN_RATE_BPS - 1) / MIN_RATE_BPS);
    // Shortest legal bit time in cycles, rounded down.
    localparam logic [15:0] MIN_BIT_CYC = 16'(CLK_HZ / MAX_RATE_BPS);
    // Runs of this many cycles or fewer are treated as line glitches.
    localparam logic [15:0] GLITCH_CYC = 16'h0008;
    // Number of line edges gathered before the rate is trusted.
    localparam logic [7:0] AUTOBAUD_EDGES = 8'h18;
    // Rate key unit: rate = key * 1e6 / 4096, so period = CLK_HZ*4096/(key*1e6).
    localparam logic [31:0] RATE_KEY_NUM = 32'((CLK_HZ / 1000000) * 4096);
    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_KEY_SEL = 4'h1;
    localparam logic [3:0] REG_KEY_VAL = 4'h2;
    localparam logic [3:0] REG_CONTROL = 4'h3;
    localparam logic [3:0] REG_RX_DATA = 4'h4;
    localparam logic [3:0] REG_TX_DATA = 4'h5;
    localparam logic [3:0] REG_BIT_PERIOD = 4'h6;
    localparam logic [3:0] REG_KEY_NUM = 4'hf;
    localparam int unsigned CTRL_WARM_RESET = 0;
    // ----------------------------------------------------------------
    // Persistent store keys and values
    // ----------------------------------------------------------------
    localparam logic [15:0] KEY_DEV_ADDR = 16'h0001;
    localparam logic [15:0] KEY_UART_RATE = 16'h01be;
    localparam logic [15:0] KEY_XTAL = 16'h01fe;
    localparam logic [15:0] KEY_VM_DISABLE = 16'h025d;
    localparam logic [15:0] KEY_HOST_IF = 16'h01f9;
    localparam logic [15:0] RST_UART_RATE = 16'h01d8;
    localparam logic [15:0] RST_XTAL = 16'h6590;
    localparam logic [15:0] RST_VM_DISABLE = 16'h0001;
    localparam logic [15:0] RST_HOST_IF = 16'h0001;
    localparam logic [15:0] HIF_RELIABLE = 16'h0001;
    localparam logic [15:0] HIF_H4 = 16'h0003;
    localparam logic [15:0] HIF_H5 = 16'h0006;
    localparam logic [15:0] HIF_H4_DEEP_SLEEP = 16'h0007;
    localparam int unsigned SLOT_RATE = 4;
    localparam int unsigned SLOT_HOST_IF = 5;
    localparam int unsigned SLOT_XTAL = 6;
    localparam int unsigned SLOT_VM = 7;
    // ----------------------------------------------------------------
    // Protocol codes (strap order: bit1, bit0)
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        PROTO_RELIABLE = 2'h0,
        PROTO_H4 = 2'h1,
        PROTO_H4_DEEP_SLEEP = 2'h2,
        PROTO_H5 = 2'h3
    } proto_t;
endpackage

// File: hw/uart_char_rx.sv
// Purpose: Receives one character: start, eight data bits LSB first, parity, stop.
// Assumes: Line input already synchronised; bit period given in clock cycles.
// Notes: Even parity is checked; a bad stop bit drops the character.
module uart_char_rx (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic enable_in,
    input wire logic line_in,
    input wire logic [15:0] bit_period_in,
    output logic [7:0] data_out,
    output logic valid_out,
    output logic parity_err_out
);
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} rx_state_t;
    rx_state_t state;
    logic [15:0] timer;
    logic [3:0] bit_idx;
    logic [8:0] shift;

    always_ff @(posedge clk_in) begin
        valid_out <= 1'b0;
        if (!rst_n_in || !enable_in) begin
            state <= RX_IDLE;
            timer <= 16'h0000;
            bit_idx <= 4'h0;
            shift <= 9'h000;
            data_out <= 8'h00;
            parity_err_out <= 1'b0;
        end else begin
            case (state)
                RX_IDLE: begin
                    if (!line_in) begin
                        state <= RX_START;
                        timer <= {1'b0, bit_period_in[15:1]};
                    end
                end
                RX_START: begin
                    if (timer != 16'h0000) begin
                        timer <= timer - 16'h0001;
                    end else if (line_in) begin
                        state <= RX_IDLE;
                    end else begin
                        state <= RX_BITS;
                        // Reload one short so that samples are exactly one bit apart.
                        timer <= bit_period_in - 16'h0001;
                        bit_idx <= 4'h0;
                    end
                end
                RX_BITS: begin
                    if (timer != 16'h0000) begin
                        timer <= timer - 16'h0001;
                    end else if (bit_idx == 4'h9) begin
                        // Stop bit sampled here.
                        state <= RX_IDLE;
                        if (line_in) begin
                            data_out <= shift[7:0];
                            parity_err_out <= ^shift;
                            valid_out <= 1'b1;
                        end
                    end else begin
                        shift <= {line_in, shift[8:1]};
                        bit_idx <= bit_idx + 4'h1;
                        timer <= bit_period_in - 16'h0001;
                    end
                end
                default: state <= RX_IDLE;
            endcase
        end
    end
endmodule

// File: hw/boot_host_interface_select.sv
// Purpose: Boot strap sampling, host port choice, rate detection, key store, warm reset.
// Assumes: Straps and the serial receive line are asynchronous pins.
// Notes: Firmware reaches the key store and the serial port through the register port.
//
// What this block does
// - Sample the interface select strap once at boot; high SDIO, low UART.
// - In UART mode decode two protocol straps: 00 reliable, 01 H4, 10 H4DS, 11 H5.
// - Keep weak pull-ups on straps so open straps read as one.
// - Infer host rate from incoming traffic; stay silent until enough samples or a warm reset loads the stored rate.
// - Keys hold device address, UART rate (01d8 is 115200) and host interface.
// - Host interface key: 0001 reliable, 0003 H4, 0006 H5, 0007 H4DS.
// - Crystal key stays 6590 and VM disable key stays 0001.
// - New keys act only after warm reset, then reboot at the configured rate.
module boot_host_interface_select (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic interface_select_strap_in,
    input wire logic proto_strap_bit1_in,
    input wire logic proto_strap_bit0_in,
    output logic strap_pullup_en_out,
    output logic sdio_enable_out,
    output logic uart_enable_out,
    output boot_sel_pkg::proto_t protocol_out,
    input wire logic uart_rx_in,
    output logic uart_tx_out,
    input wire logic [3:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [15:0] reg_rdata_out
);
    import boot_sel_pkg::*;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [3:0] sync_a;
    logic [3:0] sync_b;
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            sync_a <= 4'hf;
            sync_b <= 4'hf;
        end else begin
            sync_a <= {uart_rx_in, interface_select_strap_in,
                       proto_strap_bit1_in, proto_strap_bit0_in};
            sync_b <= sync_a;
        end
    end
    wire logic rx_line = sync_b[3];

    // Weak pull-ups stay on so that an open strap reads high.
    assign strap_pullup_en_out = 1'b1;

    // ----------------------------------------------------------------
    // Boot strap capture
    // ----------------------------------------------------------------
    logic [1:0] boot_wait;
    logic strapped;
    logic warm_reset;
    logic sdio_mode;
    proto_t protocol;
    logic [15:0] hif_key;

    function automatic proto_t hif_to_proto(input logic [15:0] key);
        case (key)
            HIF_H4: hif_to_proto = PROTO_H4;
            HIF_H5: hif_to_proto = PROTO_H5;
            HIF_H4_DEEP_SLEEP: hif_to_proto = PROTO_H4_DEEP_SLEEP;
            default: hif_to_proto = PROTO_RELIABLE;
        endcase
    endfunction

    // The strap is taken once the synchroniser has filled after reset.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            boot_wait <= 2'h0;
            strapped <= 1'b0;
            sdio_mode <= 1'b0;
            protocol <= PROTO_RELIABLE;
        end else if (!strapped) begin
            if (boot_wait == 2'h3) begin
                strapped <= 1'b1;
                sdio_mode <= sync_b[2];
                protocol <= proto_t'(sync_b[1:0]);
            end else begin
                boot_wait <= boot_wait + 2'h1;
            end
        end else if (warm_reset) begin
            protocol <= hif_to_proto(hif_key);
        end
    end

    assign sdio_enable_out = strapped && sdio_mode;
    assign uart_enable_out = strapped && !sdio_mode;
    assign protocol_out = protocol;

    // ----------------------------------------------------------------
    // Rate detection
    // ----------------------------------------------------------------
    logic rx_prev;
    logic [15:0] run_len;
    logic [15:0] min_run;
    logic [7:0] edge_count;
    logic locked;
    logic [15:0] bit_period;
    logic [15:0] rate_key;
    wire logic line_edge = rx_line != rx_prev;

    function automatic logic [15:0] rate_to_period(input logic [15:0] key);
        logic [31:0] q;
        q = 32'h0000_0000;
        if (key != 16'h0000) begin
            q = RATE_KEY_NUM / {16'h0000, key};
        end
        rate_to_period = (q[31:16] != 16'h0000) ? 16'hffff : q[15:0];
    endfunction

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rx_prev <= 1'b1;
            run_len <= 16'h0000;
            min_run <= 16'hffff;
            edge_count <= 8'h00;
            locked <= 1'b0;
            bit_period <= MAX_BIT_CYC;
        end else begin
            rx_prev <= rx_line;
            if (warm_reset) begin
                // Reboot switches straight to the stored rate.
                bit_period <= rate_to_period(rate_key);
                locked <= 1'b1;
            end else if (uart_enable_out && !locked) begin
                if (line_edge) begin
                    run_len <= 16'h0000;
                    if (run_len >= GLITCH_CYC) begin
                        edge_count <= edge_count + 8'h01;
                        if (run_len < min_run) begin
                            min_run <= run_len;
                        end
                    end
                end else if (run_len != 16'hffff) begin
                    run_len <= run_len + 16'h0001;
                end
                // Enough samples: the shortest run is one bit time.
                if (edge_count >= AUTOBAUD_EDGES) begin
                    locked <= 1'b1;
                    bit_period <= min_run + 16'h0001;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Receiver
    // ----------------------------------------------------------------
    logic [7:0] rx_data;
    logic rx_valid;
    logic rx_perr;
    uart_char_rx u_rx (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .enable_in(locked && uart_enable_out),
        .line_in(rx_line),
        .bit_period_in(bit_period),
        .data_out(rx_data),
        .valid_out(rx_valid),
        .parity_err_out(rx_perr)
    );

    // ----------------------------------------------------------------
    // Transmitter
    // ----------------------------------------------------------------
    logic [10:0] tx_shift;
    logic [3:0] tx_bits;
    logic [15:0] tx_timer;
    logic tx_start;
    logic [7:0] tx_byte;
    wire logic tx_busy = tx_bits != 4'h0;

    // Nothing leaves the device until the rate is locked.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || warm_reset) begin
            tx_shift <= 11'h7ff;
            tx_bits <= 4'h0;
            tx_timer <= 16'h0000;
        end else if (tx_start && !tx_busy && locked && uart_enable_out) begin
            tx_shift <= {1'b1, ^tx_byte, tx_byte, 1'b0};
            tx_bits <= 4'hb;
            tx_timer <= bit_period;
        end else if (tx_busy) begin
            if (tx_timer == 16'h0001 || tx_timer == 16'h0000) begin
                tx_shift <= {1'b1, tx_shift[10:1]};
                tx_bits <= tx_bits - 4'h1;
                tx_timer <= bit_period;
            end else begin
                tx_timer <= tx_timer - 16'h0001;
            end
        end
    end
    assign uart_tx_out = tx_shift[0];

    // ----------------------------------------------------------------
    // Persistent store entries
    // ----------------------------------------------------------------
    logic [15:0] key_store [0:7];
    logic [17:0] key_sel;
    logic key_violation;

    // Slots 0..3 are the device address words; others one word each.
    function automatic logic [3:0] key_slot(input logic [17:0] sel);
        case (sel[15:0])
            KEY_DEV_ADDR: key_slot = {2'b10, sel[17:16]};
            KEY_UART_RATE: key_slot = 4'(8 + SLOT_RATE);
            KEY_HOST_IF: key_slot = 4'(8 + SLOT_HOST_IF);
            KEY_XTAL: key_slot = 4'(8 + SLOT_XTAL);
            KEY_VM_DISABLE: key_slot = 4'(8 + SLOT_VM);
            default: key_slot = 4'h0;
        endcase
    endfunction

    wire logic [3:0] sel_slot = key_slot(key_sel);
    wire logic key_wr = reg_wr_in && reg_addr_in == REG_KEY_VAL && sel_slot[3];
    wire logic fixed_key = sel_slot[2:0] == 3'(SLOT_XTAL) || sel_slot[2:0] == 3'(SLOT_VM);

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            key_store[0] <= 16'h0000;
            key_store[1] <= 16'h0000;
            key_store[2] <= 16'h0000;
            key_store[3] <= 16'h0000;
            key_store[SLOT_RATE] <= RST_UART_RATE;
            key_store[SLOT_HOST_IF] <= RST_HOST_IF;
            key_store[SLOT_XTAL] <= RST_XTAL;
            key_store[SLOT_VM] <= RST_VM_DISABLE;
        end else if (key_wr && !fixed_key) begin
            key_store[sel_slot[2:0]] <= reg_wdata_in;
        end
    end
    assign rate_key = key_store[SLOT_RATE];
    assign hif_key = key_store[SLOT_HOST_IF];

    // ----------------------------------------------------------------
    // Register port
    // ----------------------------------------------------------------
    logic rx_full;
    logic rx_perr_flag;
    logic [7:0] rx_hold;

    assign warm_reset = reg_wr_in && reg_addr_in == REG_CONTROL
                        && reg_wdata_in[CTRL_WARM_RESET];
    assign tx_start = reg_wr_in && reg_addr_in == REG_TX_DATA;
    assign tx_byte = reg_wdata_in[7:0];

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            key_sel <= 18'h00000;
        end else if (reg_wr_in && reg_addr_in == REG_KEY_SEL) begin
            key_sel <= {reg_wdata_in[1:0], key_sel[15:0]};
        end else if (reg_wr_in && reg_addr_in == REG_KEY_NUM) begin
            key_sel <= {key_sel[17:16], reg_wdata_in};
        end
    end

    // Writes that would change a fixed key are refused and flagged.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            key_violation <= 1'b0;
        end else if (key_wr && fixed_key) begin
            key_violation <= 1'b1;
        end else if (reg_rd_in && reg_addr_in == REG_STATUS) begin
            key_violation <= 1'b0;
        end
    end

    // A new character wins over a read that clears the flag.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rx_full <= 1'b0;
            rx_perr_flag <= 1'b0;
            rx_hold <= 8'h00;
        end else if (rx_valid) begin
            rx_full <= 1'b1;
            rx_perr_flag <= rx_perr;
            rx_hold <= rx_data;
        end else if (reg_rd_in && reg_addr_in == REG_RX_DATA) begin
            rx_full <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= 16'h0000;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                REG_STATUS: reg_rdata_out <= {6'h00, key_violation, tx_busy, rx_perr_flag,
                                              rx_full, locked, protocol, sdio_mode, strapped,
                                              uart_enable_out};
                REG_KEY_SEL: reg_rdata_out <= {14'h0000, key_sel[17:16]};
                REG_KEY_NUM: reg_rdata_out <= key_sel[15:0];
                REG_KEY_VAL: reg_rdata_out <= sel_slot[3] ? key_store[sel_slot[2:0]] : 16'h0000;
                REG_RX_DATA: reg_rdata_out <= {8'h00, rx_hold};
                REG_BIT_PERIOD: reg_rdata_out <= bit_period;
                default: reg_rdata_out <= 16'h0000;
            endcase
        end else begin
            reg_rdata_out <= 16'h0000;
        end
    end
endmodule

// File: verification/host_uart_model.sv
// Purpose: Host side serial sender that feeds rate detection traffic to the module.
// Assumes: One clock; bit time given in clock cycles.
// Notes: The line idles high, the level the pull-up leaves on it.
module host_uart_model #(
    parameter int BIT_CYC = 347
) (
    input wire logic clk_in,
    input wire logic send_in,
    input wire logic [7:0] data_in,
    output logic line_out,
    output logic busy_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [10:0] frame;
    initial begin
        line_out = 1'b1;
        busy_out = 1'b0;
        forever begin
            @(posedge clk_in);
            if (send_in) begin
                busy_out <= 1'b1;
                frame = {1'b1, ^data_in, data_in, 1'b0};
                for (int b = 0; b < 11; b++) begin
                    line_out <= frame[b];
                    repeat (BIT_CYC) @(posedge clk_in);
                end
                busy_out <= 1'b0;
            end
        end
    end
endmodule

// File: verification/boot_host_interface_select_props.sv
// Purpose: Port level checks for strap capture, register reads and the serial output.
// Assumes: One clock domain, synchronous active low reset.
// Notes: Attached to every instance of the top module by bind.
module boot_host_interface_select_props (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic interface_select_strap_in,
    input wire logic proto_strap_bit1_in,
    input wire logic proto_strap_bit0_in,
    input wire logic strap_pullup_en_out,
    input wire logic sdio_enable_out,
    input wire logic uart_enable_out,
    input wire boot_sel_pkg::proto_t protocol_out,
    input wire logic uart_rx_in,
    input wire logic uart_tx_out,
    input wire logic [3:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [15:0] reg_rdata_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import boot_sel_pkg::*;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);
    pullup_on_a: assert property (strap_pullup_en_out)
        else $error("strap pull-up disabled");
    one_port_a: assert property (!(sdio_enable_out && uart_enable_out))
        else $error("both host ports enabled");
    sdio_kept_a: assert property (sdio_enable_out |=> sdio_enable_out)
        else $error("sdio port dropped after boot");
    uart_kept_a: assert property (uart_enable_out |=> uart_enable_out)
        else $error("uart port dropped after boot");
    rdata_idle_a: assert property (!reg_rd_in |=> reg_rdata_out == 16'h0000)
        else $error("read data outside read answer");
    status_ports_a: assert property (reg_rd_in && reg_addr_in == REG_STATUS |=>
        reg_rdata_out[4:2] == {$past(protocol_out), $past(sdio_enable_out)})
        else $error("status does not match port choice");
    tx_silent_a: assert property (!uart_enable_out |-> uart_tx_out)
        else $error("serial output active without uart");
    start_bit_a: assert property ($fell(uart_tx_out) |=> !uart_tx_out [*7])
        else $error("start bit too short");
    proto_hold_a: assert property (uart_enable_out &&
        !(reg_wr_in && reg_addr_in == REG_CONTROL) |=> $stable(protocol_out))
        else $error("protocol changed without warm reset");
endmodule
bind boot_host_interface_select boot_host_interface_select_props i_props (.clk_in, .rst_n_in,
    .interface_select_strap_in, .proto_strap_bit1_in, .proto_strap_bit0_in,
    .strap_pullup_en_out, .sdio_enable_out, .uart_enable_out, .protocol_out, .uart_rx_in,
    .uart_tx_out, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out);

// File: verification/boot_host_interface_select_test.sv
// Purpose: Self-checking bench for strap choice, rate detection, key store and warm reset.
// Assumes: 40 MHz clock; host traffic at 115200 bps from the partner model.
// Notes: Register reads are noted in a queue and judged by a monitor process.
module boot_host_interface_select_test import boot_sel_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in, rst_n_in, iface, pb1, pb0, sdio_en, uart_en, tx, rx, reg_wr, reg_rd, rd_d;
    logic hsend, hbusy;
    logic [7:0] hdata;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata, rdata, k, v;
    proto_t proto;
    logic [15:0] exp_q[$], mask_q[$];
    logic [15:0] hif[4] = '{HIF_RELIABLE, HIF_H4, HIF_H4_DEEP_SLEEP, HIF_H5};
    int fails, checks, seed;
    boot_host_interface_select i_boot_host_interface_select (.clk_in(clk_in),
        .rst_n_in(rst_n_in), .interface_select_strap_in(iface), .proto_strap_bit1_in(pb1),
        .proto_strap_bit0_in(pb0), .strap_pullup_en_out(), .sdio_enable_out(sdio_en),
        .uart_enable_out(uart_en), .protocol_out(proto), .uart_rx_in(rx), .uart_tx_out(tx),
        .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
        .reg_rd_in(reg_rd), .reg_rdata_out(rdata));
    host_uart_model #(.BIT_CYC(347)) i_host_uart_model (.clk_in(clk_in), .send_in(hsend),
        .data_in(hdata), .line_out(rx), .busy_out(hbusy));
    // --------------------------------------------------------------
    // Tasks
    // --------------------------------------------------------------
    task automatic results();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stuck();
        check("wait bound", 16'h0001, 16'h0000);
        results();
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_in);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_in);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
        @(posedge clk_in);
        reg_rd <= 1'b1;
        reg_addr <= a;
        mask_q.push_back(m);
        exp_q.push_back(e & m);
        @(posedge clk_in);
        reg_rd <= 1'b0;
    endtask
    task automatic key_wr(input logic [15:0] key, input logic [15:0] d);
        wr(REG_KEY_NUM, key);
        wr(REG_KEY_SEL, 16'h0000);
        wr(REG_KEY_VAL, d);
    endtask
    task automatic key_rd(input logic [15:0] key, input logic [15:0] e);
        wr(REG_KEY_NUM, key);
        wr(REG_KEY_SEL, 16'h0000);
        rd(REG_KEY_VAL, 16'hffff, e);
    endtask
    task automatic boot(input logic s, input logic b1, input logic b0);
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        iface <= s;
        pb1 <= b1;
        pb0 <= b0;
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'b1;
        for (int n = 0; !(sdio_en || uart_en); n++) begin
            if (n == 20) stuck();
            @(posedge clk_in);
        end
    endtask
    task automatic send(input logic [7:0] d);
        @(posedge clk_in);
        hsend <= 1'b1;
        hdata <= d;
        @(posedge clk_in);
        hsend <= 1'b0;
        // The model raises busy on the edge that takes the request.
        @(posedge clk_in);
        for (int n = 0; hbusy; n++) begin
            if (n == 5000) stuck();
            @(posedge clk_in);
        end
    endtask
    task automatic tx_frame(input int p, input logic [7:0] d);
        logic [15:0] f;
        f = 16'h0000;
        wr(REG_TX_DATA, {8'h00, d});
        for (int n = 0; tx; n++) begin
            if (n == 50) stuck();
            @(posedge clk_in);
        end
        repeat (p / 2) @(posedge clk_in);
        for (int b = 0; b < 11; b++) begin
            f[b] = tx;
            repeat (p) @(posedge clk_in);
        end
        check("tx frame", f, {5'h00, 1'b1, ^d, d, 1'b0});
    endtask
    // --------------------------------------------------------------
    // Read answer monitor
    // --------------------------------------------------------------
    always @(posedge clk_in) begin
        if (rd_d) begin
            check("read data", rdata & mask_q.pop_front(), exp_q.pop_front());
        end
        rd_d <= reg_rd;
    end
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        {rst_n_in, iface, pb1, pb0, reg_wr, reg_rd, hsend} = 7'h00;
        {reg_addr, reg_wdata, hdata} = 28'h0;
        {fails, checks} = 64'h0;
        seed = 32'hfe39c9a8;
        for (int c = 0; c < 5; c++) begin
            boot(c == 4, c[1], c[0]);
            check("sdio enable", {15'h0, sdio_en}, {15'h0, c == 4});
            check("uart enable", {15'h0, uart_en}, {15'h0, c != 4});
            if (c < 4) check("protocol", {14'h0, proto}, 16'(c));
            rd(REG_STATUS, c == 4 ? 16'h0007 : 16'h001f, 16'({c, 3'(c == 4 ? 6 : 3)}));
        end
        boot(1'b0, 1'b0, 1'b0);
        rd(REG_STATUS, 16'h0020, 16'h0000);
        foreach (hif[i]) send(8'h55 ^ 8'(i * 8'h6b));
        send(8'h3c);
        rd(REG_STATUS, 16'h00e0, 16'h0060);
        rd(REG_RX_DATA, 16'h00ff, 16'h003c);
        rd(REG_BIT_PERIOD, 16'hfff8, 16'h0158);
        tx_frame(347, 8'($random(seed)));
        key_rd(KEY_UART_RATE, RST_UART_RATE);
        key_rd(KEY_HOST_IF, RST_HOST_IF);
        v = 16'($random(seed));
        key_wr(KEY_XTAL, v);
        key_rd(KEY_XTAL, RST_XTAL);
        rd(REG_STATUS, 16'h0200, 16'h0200);
        rd(REG_STATUS, 16'h0200, 16'h0000);
        key_wr(KEY_VM_DISABLE, ~RST_VM_DISABLE);
        key_rd(KEY_VM_DISABLE, RST_VM_DISABLE);
        for (int h = 3; h >= 0; h--) begin
            key_wr(KEY_HOST_IF, hif[h]);
            check("proto before", {14'h0, proto}, h == 3 ? 16'h0 : 16'(h + 1));
            wr(REG_CONTROL, 16'h0001);
            @(posedge clk_in);
            check("proto after", {14'h0, proto}, 16'(h));
        end
        rd(REG_BIT_PERIOD, 16'hffff, 16'd347);
        k = 16'h0100 + (16'($random(seed)) & 16'h0eff);
        key_wr(KEY_UART_RATE, k);
        wr(REG_CONTROL, 16'h0001);
        rd(REG_BIT_PERIOD, 16'hffff, 16'(163840 / k));
        tx_frame(163840 / k, 8'($random(seed)));
        boot(1'b0, 1'b1, 1'b1);
        rd(REG_STATUS, 16'h0020, 16'h0000);
        repeat (3) @(posedge clk_in);
        results();
    end
endmodule
